//--- cis_pkg.sv
// package: constants, types and helpers of the core interrupt sequencer
`default_nettype none
package cis_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_IRQ = 42; // priority 0 highest .. 41 lowest
    localparam int IDX_W = 6; // width of an interrupt index
    localparam int PC_W = 24; // fetch address width
    localparam int MODE_W = 32; // mode control register width
    localparam int ASTAT_W = 32; // packed arithmetic status width
    localparam int EXT_N = 3; // external request inputs
    localparam int BOOT_W = 2; // boot configuration pins
    localparam int STAT_W = MODE_W + ASTAT_W;

    // ----------------------------------------------------------------
    // mode control register fields and reset value
    // ----------------------------------------------------------------
    localparam int MODE_NEST_BIT = 11;  // nesting mode bit
    localparam int MODE_GIE_BIT = 12;   // global interrupt enable bit
    localparam logic [MODE_W-1:0] MODE_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // latch / mask bit positions
    // ----------------------------------------------------------------
    localparam int IRQ_RESET = 0; // reset, never masked
    localparam int IRQ_EMU = 1; // emulator, never masked
    localparam int IRQ_TMR_HI = 3; // core timer, high priority
    localparam int IRQ_EXT_BASE = 7; // external input 0 .. 2 at 7 .. 9
    localparam int IRQ_BOOT_BASE = 16; // boot sources 16 .. 19
    localparam int IRQ_TMR_LO = 36; // core timer, low priority
    localparam logic [NUM_IRQ-1:0] NONMASK = 42'h000_0000_0003;
    // sources whose entry saves status: external inputs and timer
    localparam logic [NUM_IRQ-1:0] STAT_PUSH = 42'h010_0000_0388;
    localparam logic [NUM_IRQ-1:0] MASK_RESET = 42'h000_0000_0000;
    localparam logic [NUM_IRQ-1:0] LATCH_RESET = 42'h000_0000_0000;

    // ----------------------------------------------------------------
    // vector table
    // ----------------------------------------------------------------
    localparam logic [PC_W-1:0] VEC_BASE = 24'h00_0000;
    localparam logic [PC_W-1:0] VEC_SPACING = 24'h00_0004; // instructions per slot
    localparam int SYNC_STAGES = 2;  // flops on each pin input

    // ----------------------------------------------------------------
    // boot unmask sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_SYNC0 = 4'h1,
        ST_SYNC1 = 4'h2,
        ST_UNMASK = 4'h4,
        ST_RUN = 4'h8
    } cis_boot_st_t;

    // index of the highest priority (lowest numbered) set bit
    function automatic logic [IDX_W-1:0] cis_first(input logic [NUM_IRQ-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction : cis_first
endpackage : cis_pkg
`default_nettype wire

//--- cis_stk_if.sv
// interface: push/pop/overwrite port between the sequencer and a stack
`default_nettype none
interface cis_stk_if #(parameter int W = 8);
    logic push; // store din as new top
    logic pop; // drop top
    logic wr_top; // overwrite top with din
    logic [W-1:0] din; // data for push or overwrite
    logic [W-1:0] top; // current top, zero when empty
    logic empty; // no entry held
    logic full; // no room left
    modport owner (output push, output pop, output wr_top, output din,
                   input top, input empty, input full);
    modport stack (input push, input pop, input wr_top, input din,
                   output top, output empty, output full);
endinterface : cis_stk_if
`default_nettype wire

//--- cis_irq_sync.sv
// module: pin synchroniser and level/edge detection for external requests
`default_nettype none
module cis_irq_sync #(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pins and configuration
    input wire logic [N-1:0] pins,
    input wire logic [N-1:0] edge_mode,
    // request toward the latch
    output logic [N-1:0] req
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (N < 1) begin : g_chk
        $error("cis_irq_sync needs at least one input");
    end

    logic [N-1:0] s1_q, s2_q, s3_q; // first, second sync stage, history
    logic [N-1:0] s1_d, s2_d, s3_d;

    // next values: s1 is read only by s2, detection looks at s2 and s3
    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // per input choice of level or rising edge
    for (genvar i = 0; i < N; i++) begin : g_det
        assign req[i] = edge_mode[i] ? (s2_q[i] & ~s3_q[i]) : s2_q[i];
    end
endmodule : cis_irq_sync
`default_nettype wire

//--- cis_stack.sv
// module: flip-flop LIFO with push, pop and overwrite of the top entry
`default_nettype none
module cis_stack #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // stack port
    cis_stk_if.stack port
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DEPTH < 1 || W < 1) begin : g_chk
        $error("cis_stack needs positive width and depth");
    end

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [W-1:0] mem_q [DEPTH]; // entries, index 0 is the bottom
    logic [W-1:0] mem_d [DEPTH];
    logic [CW-1:0] cnt_q, cnt_d; // entries held, empty at reset

    // next values: push beats pop, an overwrite needs a held entry
    always_comb begin
        mem_d = mem_q;
        cnt_d = cnt_q;
        if (port.push && cnt_q != FULL_CNT) begin
            mem_d[cnt_q] = port.din;
            cnt_d = cnt_q + 1'b1;
        end else if (port.pop && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end else if (port.wr_top && cnt_q != '0) begin
            mem_d[cnt_q - 1'b1] = port.din;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    assign port.empty = (cnt_q == '0);
    assign port.full = (cnt_q == FULL_CNT);
    assign port.top = (cnt_q == '0) ? '0 : mem_q[cnt_q - 1'b1];
endmodule : cis_stack
`default_nettype wire

//--- cis_sequencer.sv
// module: core interrupt sequencer, latch, arbitration, vectoring, return
// Operation
// - write to stack top replaces delayed-call push
// - no servicing until global enable set
// - three maskable external inputs, level or edge
// - requests synchronised, then set latch bits
// - respond only active, unmasked, enabled, highest
// - vectors spaced four instructions apart
// - entry outputs vector, pushes return address
// - entry saves status for external/timer sources
// - entry clears the serviced latch bit
// - entry sets mask pointer bit, nesting mode picks what it blocks
// - return resumes at stack top, pops it
// - return restores status only if saved
// - return clears the ending mask pointer bit
// - all but reset/emulator maskable, still latch
// - reset masks everything except non-maskables
// - after reset unmask pin-selected boot source
// - return stack empty after reset
// - two cycle sync, one cycle latch
// - fixed priority, bit 0 highest, 41 lowest
// - in-service latch bit cleared every cycle
`default_nettype none
module cis_sequencer #(
    parameter int RSTK_DEPTH = 30,
    parameter int SSTK_DEPTH = 15
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pins
    input wire logic [cis_pkg::EXT_N-1:0] external_irq_inputs,
    input wire logic [cis_pkg::EXT_N-1:0] irq_edge_mode,
    input wire logic [cis_pkg::BOOT_W-1:0] boot_config_pins,
    // internal event pulses, one per latch bit
    input wire logic [cis_pkg::NUM_IRQ-1:0] internal_irq_events,
    // core state
    input wire logic core_active,
    input wire logic in_delay_branch,
    input wire logic [cis_pkg::PC_W-1:0] current_pc,
    input wire logic [cis_pkg::ASTAT_W-1:0] arith_status_regs,
    // sequencer operations
    input wire logic call_push,
    input wire logic [cis_pkg::PC_W-1:0] call_ret_addr,
    input wire logic rstk_wr_en,
    input wire logic [cis_pkg::PC_W-1:0] rstk_wr_data,
    input wire logic rts_exec,
    input wire logic rti_exec,
    // software register writes
    input wire logic mode_wr_en,
    input wire logic [cis_pkg::MODE_W-1:0] mode_wr_data,
    input wire logic mask_wr_en,
    input wire logic [cis_pkg::NUM_IRQ-1:0] mask_wr_data,
    input wire logic latch_wr_en,
    input wire logic [cis_pkg::NUM_IRQ-1:0] latch_wr_data,
    // register views
    output logic [cis_pkg::MODE_W-1:0] mode_control_reg,
    output logic [cis_pkg::NUM_IRQ-1:0] irq_mask_reg,
    output logic [cis_pkg::NUM_IRQ-1:0] irq_latch_reg,
    output logic [cis_pkg::NUM_IRQ-1:0] irq_mask_pointer_reg,
    output logic global_irq_enable,
    output logic nesting_mode_bit,
    // interrupt entry
    output logic vector_valid,
    output logic [cis_pkg::PC_W-1:0] vector_addr,
    output logic [cis_pkg::IDX_W-1:0] vector_index,
    // return
    output logic resume_valid,
    output logic [cis_pkg::PC_W-1:0] resume_addr,
    output logic status_restore_valid,
    output logic [cis_pkg::ASTAT_W-1:0] arith_status_restore,
    // return stack view
    output logic [cis_pkg::PC_W-1:0] return_stack_top,
    output logic return_stack_empty
);
    import cis_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (RSTK_DEPTH < 1 || SSTK_DEPTH < 1) begin : g_chk
        $error("cis_sequencer needs stacks of depth one or more");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [MODE_W-1:0] mode_q, mode_d; // mode control register
    logic [NUM_IRQ-1:0] mask_q, mask_d; // mask register
    logic [NUM_IRQ-1:0] latch_q, latch_d; // latch register
    logic [NUM_IRQ-1:0] mptr_q, mptr_d; // mask pointer, in-service bits
    logic [NUM_IRQ-1:0] saved_q, saved_d; // status was pushed at entry
    cis_boot_st_t boot_st_q, boot_st_d; // boot unmask sequencer
    logic [BOOT_W-1:0] boot_s1_q, boot_s2_q; // boot pin synchroniser
    logic vec_valid_q, vec_valid_d; // entry pulse
    logic [PC_W-1:0] vec_addr_q, vec_addr_d;
    logic [IDX_W-1:0] vec_idx_q, vec_idx_d;
    logic res_valid_q, res_valid_d; // return pulse
    logic [PC_W-1:0] res_addr_q, res_addr_d;
    logic st_valid_q, st_valid_d; // status restore pulse
    logic [ASTAT_W-1:0] st_astat_q, st_astat_d;

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    logic [NUM_IRQ-1:0] ext_set; // synchronised external requests
    logic [EXT_N-1:0] ext_req;
    logic [NUM_IRQ-1:0] blocked; // blocked by an active routine
    logic [NUM_IRQ-1:0] eligible; // latched, unmasked, unblocked
    logic [IDX_W-1:0] take_idx; // winner of arbitration
    logic [IDX_W-1:0] end_idx; // routine that a return ends
    logic take; // interrupt entry this cycle
    logic ret_irq; // interrupt return this cycle
    logic gie;
    logic nest;

    cis_stk_if #(.W(PC_W)) rstk_if ();
    cis_stk_if #(.W(STAT_W)) sstk_if ();

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    cis_irq_sync #(.N(EXT_N)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .pins(external_irq_inputs),
        .edge_mode(irq_edge_mode),
        .req(ext_req)
    );

    cis_stack #(.W(PC_W), .DEPTH(RSTK_DEPTH)) u_rstk (
        .clock(clock),
        .resetn(resetn),
        .port(rstk_if)
    );

    cis_stack #(.W(STAT_W), .DEPTH(SSTK_DEPTH)) u_sstk (
        .clock(clock),
        .resetn(resetn),
        .port(sstk_if)
    );

    // place external requests on their latch bits
    always_comb begin
        ext_set = '0;
        ext_set[IRQ_EXT_BASE +: EXT_N] = ext_req;
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    assign gie = mode_q[MODE_GIE_BIT];
    assign nest = mode_q[MODE_NEST_BIT];
    assign end_idx = cis_first(mptr_q);
    assign ret_irq = rti_exec && (mptr_q != '0);

    // nesting lets only higher priority through; otherwise one at a time
    always_comb begin
        blocked = '0;
        if (mptr_q != '0) begin
            if (nest) begin
                blocked = ~((NUM_IRQ'(1) << end_idx) - NUM_IRQ'(1));
            end else begin
                blocked = '1;
            end
        end
    end

    // masked bits stay latched and win later once unmasked
    assign eligible = latch_q & (mask_q | NONMASK) & ~blocked;
    assign take_idx = cis_first(eligible);
    // the stack port serves one operation per cycle, so entry yields
    // to calls, returns and software writes of the top
    assign take = (eligible != '0) && gie && core_active && !in_delay_branch
                  && (boot_st_q == ST_RUN) && !call_push && !rstk_wr_en
                  && !rts_exec && !rti_exec;

    // ----------------------------------------------------------------
    // stacks
    // ----------------------------------------------------------------
    // a software write of the top wins over the value a call pushes
    assign rstk_if.push = call_push | take;
    assign rstk_if.pop = rts_exec | rti_exec;
    assign rstk_if.wr_top = rstk_wr_en;
    assign rstk_if.din = rstk_wr_en ? rstk_wr_data : (take ? current_pc : call_ret_addr);
    assign sstk_if.push = take && STAT_PUSH[take_idx];
    assign sstk_if.pop = ret_irq && saved_q[end_idx];
    assign sstk_if.wr_top = 1'b0;
    assign sstk_if.din = {mode_q, arith_status_regs};

    // ----------------------------------------------------------------
    // interrupt state next values
    // ----------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        mask_d = mask_q;
        latch_d = latch_q;
        mptr_d = mptr_q;
        saved_d = saved_q;
        boot_st_d = boot_st_q;
        // boot source unmask once the pins have crossed both stages
        case (boot_st_q)
            ST_SYNC0: begin
                boot_st_d = ST_SYNC1;
            end
            ST_SYNC1: begin
                boot_st_d = ST_UNMASK;
            end
            ST_UNMASK: begin
                mask_d[IRQ_BOOT_BASE + int'(boot_s2_q)] = 1'b1;
                boot_st_d = ST_RUN;
            end
            ST_RUN: begin
                boot_st_d = ST_RUN;
            end
            default: begin
                boot_st_d = ST_SYNC0;
            end
        endcase
        // software writes
        if (mode_wr_en) begin
            mode_d = mode_wr_data;
        end
        if (mask_wr_en && boot_st_q == ST_RUN) begin
            mask_d = mask_wr_data;
        end
        // reset and emulator bits are not software writable
        if (latch_wr_en) begin
            latch_d = (latch_wr_data & ~NONMASK) | (latch_q & NONMASK);
        end
        latch_d = latch_d | internal_irq_events | ext_set;
        // entry
        if (take) begin
            mptr_d[take_idx] = 1'b1;
            saved_d[take_idx] = STAT_PUSH[take_idx];
        end
        // return
        if (ret_irq) begin
            mptr_d[end_idx] = 1'b0;
            saved_d[end_idx] = 1'b0;
            if (saved_q[end_idx]) begin
                mode_d = sstk_if.top[STAT_W-1 -: MODE_W];
            end
        end
        // in-service bits and the bit just taken cannot re-latch; this
        // clear wins over a new event, unlike the other flags
        latch_d = latch_d & ~mptr_q;
        if (take) begin
            latch_d[take_idx] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_q <= MODE_RESET;
            mask_q <= MASK_RESET;
            latch_q <= LATCH_RESET;
            mptr_q <= '0;
            saved_q <= '0;
            boot_st_q <= ST_SYNC0;
        end else begin
            mode_q <= mode_d;
            mask_q <= mask_d;
            latch_q <= latch_d;
            mptr_q <= mptr_d;
            saved_q <= saved_d;
            boot_st_q <= boot_st_d;
        end
    end

    // boot pins come from outside: two flops before use
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            boot_s1_q <= '0;
            boot_s2_q <= '0;
        end else begin
            boot_s1_q <= boot_config_pins;
            boot_s2_q <= boot_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // output pulses and data next values
    // ----------------------------------------------------------------
    always_comb begin
        vec_valid_d = take;
        vec_addr_d = vec_addr_q;
        vec_idx_d = vec_idx_q;
        res_valid_d = rts_exec | rti_exec;
        res_addr_d = res_addr_q;
        st_valid_d = sstk_if.pop;
        st_astat_d = st_astat_q;
        if (take) begin
            vec_addr_d = VEC_BASE + PC_W'(take_idx) * VEC_SPACING;
            vec_idx_d = take_idx;
        end
        if (rts_exec || rti_exec) begin
            res_addr_d = rstk_if.top;
        end
        if (sstk_if.pop) begin
            st_astat_d = sstk_if.top[ASTAT_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vec_valid_q <= 1'b0;
            vec_addr_q <= '0;
            vec_idx_q <= '0;
            res_valid_q <= 1'b0;
            res_addr_q <= '0;
            st_valid_q <= 1'b0;
            st_astat_q <= '0;
        end else begin
            vec_valid_q <= vec_valid_d;
            vec_addr_q <= vec_addr_d;
            vec_idx_q <= vec_idx_d;
            res_valid_q <= res_valid_d;
            res_addr_q <= res_addr_d;
            st_valid_q <= st_valid_d;
            st_astat_q <= st_astat_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign mode_control_reg = mode_q;
    assign irq_mask_reg = mask_q;
    assign irq_latch_reg = latch_q;
    assign irq_mask_pointer_reg = mptr_q;
    assign global_irq_enable = gie;
    assign nesting_mode_bit = nest;
    assign vector_valid = vec_valid_q;
    assign vector_addr = vec_addr_q;
    assign vector_index = vec_idx_q;
    assign resume_valid = res_valid_q;
    assign resume_addr = res_addr_q;
    assign status_restore_valid = st_valid_q;
    assign arith_status_restore = st_astat_q;
    assign return_stack_top = rstk_if.top;
    assign return_stack_empty = rstk_if.empty;
endmodule : cis_sequencer
`default_nettype wire

//--- cis_sequencer_asserts.sv
// checker: concurrent properties on the sequencer's top ports
`default_nettype none
module cis_sequencer_asserts import cis_pkg::*; (
    // clock, reset, core operations and one-bit results
    input wire logic clock, resetn, core_active, in_delay_branch, call_push, rstk_wr_en, rts_exec, rti_exec,
    input wire logic global_irq_enable, vector_valid, resume_valid, status_restore_valid, return_stack_empty,
    // words
    input wire logic [PC_W-1:0] current_pc, rstk_wr_data, vector_addr, resume_addr, return_stack_top,
    input wire logic [NUM_IRQ-1:0] irq_mask_reg, irq_latch_reg, irq_mask_pointer_reg,
    input wire logic [IDX_W-1:0] vector_index
);
    // one clock domain
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    gie_gate_a: assert property (vector_valid |-> $past(global_irq_enable)) else $error("entry while disabled");
    core_state_a: assert property (vector_valid |-> $past(core_active && !in_delay_branch))
        else $error("entry while core not ready");
    vec_spacing_a: assert property (vector_valid |-> vector_addr == VEC_BASE + 24'(vector_index) * 4)
        else $error("vector address off table");
    pc_push_a: assert property (vector_valid |-> return_stack_top == $past(current_pc))
        else $error("return address not pushed");
    latch_clr_a: assert property (vector_valid |-> !irq_latch_reg[vector_index]) else $error("latch bit kept");
    ptr_set_a: assert property (vector_valid |-> irq_mask_pointer_reg[vector_index]) else $error("pointer not set");
    mask_gate_a: assert property (vector_valid |-> |($past(irq_mask_reg | NONMASK) & (NUM_IRQ'(1) << vector_index)))
        else $error("masked source entered");
    rti_resume_a: assert property (rti_exec && !return_stack_empty |=> resume_valid && resume_addr == $past(return_stack_top))
        else $error("wrong resume");
    stat_pop_a: assert property (status_restore_valid |-> $past(rti_exec)) else $error("stray status pop");
    ptr_clear_a: assert property (rti_exec && |irq_mask_pointer_reg |=>
        irq_mask_pointer_reg == $past(irq_mask_pointer_reg & (irq_mask_pointer_reg - 1'b1))) else $error("pointer not cleared");
    top_write_a: assert property (rstk_wr_en && !return_stack_empty && !(call_push || rts_exec || rti_exec) |=>
        return_stack_top == $past(rstk_wr_data)) else $error("stack top not replaced");
    reset_state_a: assert property (!$past(resetn) |-> return_stack_empty && irq_mask_reg == MASK_RESET)
        else $error("bad state after reset");
    // main scenarios reached
    cov_entry: cover property (vector_valid);
    cov_status: cover property (status_restore_valid);
    cov_plain_ret: cover property (resume_valid && !status_restore_valid);
endmodule : cis_sequencer_asserts
bind cis_sequencer cis_sequencer_asserts i_chk (.*);
`default_nettype wire

//--- cis_irq_src.sv
// model: external devices driving the three request pins
`default_nettype none
module cis_irq_src import cis_pkg::*; (
    // clock and raise/drop commands
    input wire logic clock,
    input wire logic [EXT_N-1:0] raise, drop,
    // request pins, moved off the core edge
    output logic [EXT_N-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    // a level request is held until dropped
    always @(posedge clock) pins <= #3 (pins | raise) & ~drop;
endmodule : cis_irq_src
`default_nettype wire

//--- cis_sequencer_tb_top.sv
// testbench: directed scenarios for the core interrupt sequencer
`default_nettype none
module cis_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cis_pkg::*;
    logic clock, resetn, core_active, in_delay_branch, call_push, rstk_wr_en, rts_exec, rti_exec, mode_wr_en;
    logic mask_wr_en, latch_wr_en, global_irq_enable, nesting_mode_bit, vector_valid, resume_valid;
    logic status_restore_valid, return_stack_empty;
    logic [EXT_N-1:0] ext_pins, edge_mode, raise, drop;
    logic [BOOT_W-1:0] boot_pins;
    logic [NUM_IRQ-1:0] events, mask_wr_data, latch_wr_data, irq_mask_reg, irq_latch_reg, irq_mask_pointer_reg;
    logic [PC_W-1:0] current_pc, call_ret_addr, rstk_wr_data, vector_addr, resume_addr, return_stack_top;
    logic [MODE_W-1:0] mode_wr_data, mode_control_reg;
    logic [ASTAT_W-1:0] arith_status_regs, arith_status_restore;
    logic [IDX_W-1:0] vector_index;
    int num_errors, checks_done;
    cis_sequencer i_dut (.*, .external_irq_inputs(ext_pins), .irq_edge_mode(edge_mode),
        .boot_config_pins(boot_pins), .internal_irq_events(events));
    cis_irq_src i_src (.clock(clock), .raise(raise), .drop(drop), .pins(ext_pins));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // step n edges, then land just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test(input bit hung);
        if (hung) num_errors++;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // bounded wait for an entry pulse
    task automatic wait_vec(input logic [IDX_W-1:0] idx);
        for (int i = 0; i < 20 && vector_valid !== 1'b1; i++) cyc(1);
        if (vector_valid !== 1'b1) end_of_test(1);
        chk("vector_index", idx, vector_index);
        chk("vector_addr", VEC_BASE + VEC_SPACING * idx, vector_addr);
    endtask : wait_vec
    task automatic no_vec(input int n);
        repeat (n) begin
            cyc(1);
            chk("vector_valid", 0, vector_valid);
        end
    endtask : no_vec
    task automatic ret(input logic rti, input logic [PC_W-1:0] addr, input logic stat);
        {rti_exec, rts_exec} = {rti, !rti};
        cyc(1);
        {rti_exec, rts_exec} = 2'h0;
        chk("resume_addr", addr, resume_addr);
        chk("status_restore_valid", stat, status_restore_valid);
    endtask : ret
    task automatic wr_mask(input logic [NUM_IRQ-1:0] m, input logic [NUM_IRQ-1:0] ev);
        {mask_wr_en, mask_wr_data, events} = {1'b1, m, ev};
        cyc(1);
        {mask_wr_en, events} = '0;
    endtask : wr_mask
    initial begin
        {resetn, core_active, in_delay_branch, call_push, rstk_wr_en, rts_exec, rti_exec, mode_wr_en} = '0;
        {mask_wr_en, latch_wr_en, raise, drop, edge_mode, events, mask_wr_data, latch_wr_data} = '0;
        {current_pc, call_ret_addr, rstk_wr_data, mode_wr_data} = '0;
        {arith_status_regs, num_errors, checks_done} = '0;
        boot_pins = 2'h2;
        cyc(3);
        chk("return_stack_empty", 1, return_stack_empty);
        resetn = 1;
        cyc(4);
        chk("irq_mask_reg", MASK_RESET | 42'h4_0000, irq_mask_reg);
        $display("test reset done");
        {core_active, current_pc} = {1'b1, 24'h00_0123};
        raise = 3'h1;
        cyc(1);
        raise = 3'h0;
        cyc(2);
        chk("latch bit 7 early", 0, irq_latch_reg[7]);
        cyc(1);
        chk("latch bit 7", 1, irq_latch_reg[7]);
        wr_mask(42'h14_0080, '0);
        no_vec(2);
        {mode_wr_en, mode_wr_data} = {1'b1, 32'h0000_1000};
        cyc(1);
        mode_wr_en = 0;
        wait_vec(7);
        chk("return_stack_top", 24'h00_0123, return_stack_top);
        cyc(3);
        chk("latch bit 7 held low", 0, irq_latch_reg[7]);
        drop = 3'h1;
        cyc(1);
        drop = 3'h0;
        $display("test pin entry done");
        {core_active, events} = {1'b0, 42'h10_0010_0008};
        cyc(1);
        events = '0;
        no_vec(3);
        ret(1, 24'h00_0123, 1);
        chk("irq_mask_pointer_reg", 0, irq_mask_pointer_reg);
        {core_active, current_pc} = {1'b1, 24'h00_0456};
        wait_vec(20);
        chk("latch bit 3", 1, irq_latch_reg[3]);
        ret(1, 24'h00_0456, 0);
        current_pc = 24'h00_0789;
        wr_mask(42'h14_0088, 42'h10_0000);
        wait_vec(3);
        ret(1, 24'h00_0789, 1);
        wait_vec(20);
        ret(1, 24'h00_0789, 0);
        $display("test priority done");
        {in_delay_branch, call_push, call_ret_addr} = {2'h3, 24'h09_0103};
        cyc(1);
        {call_push, rstk_wr_en, rstk_wr_data} = {2'h1, 24'h09_0200};
        cyc(1);
        {rstk_wr_en, in_delay_branch} = 2'h0;
        chk("return_stack_top", 24'h09_0200, return_stack_top);
        ret(0, 24'h09_0200, 0);
        chk("return_stack_empty", 1, return_stack_empty);
        $display("test delayed call done");
        end_of_test(0);
    end
endmodule : cis_sequencer_tb_top
`default_nettype wire
